// ===== common/timer_pkg.sv
// constants for the compact timer
package timer_pkg;
	localparam logic [1:0] ADDR_CMP_LOW  = 2'h0;
	localparam logic [1:0] ADDR_CMP_HIGH = 2'h1;
	localparam logic [1:0] ADDR_CTRL_0   = 2'h2;
	localparam logic [1:0] ADDR_CTRL_1   = 2'h3;
	localparam int ADDR_WIDTH = 2;
	localparam int COUNT_WIDTH = 10;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [9:0] COUNT_MAX = 10'h3FF;
	// control 0 field positions
	localparam int C0_PAUSE = 7;
	localparam int C0_CLK_HI = 6;
	localparam int C0_CLK_LO = 4;
	localparam int C0_ON = 3;
	localparam int C0_PER_HI = 2;
	// control 1 field positions
	localparam int C1_MODE_HI = 7;
	localparam int C1_MODE_LO = 6;
	localparam int C1_ACT_HI = 5;
	localparam int C1_ACT_LO = 4;
	localparam int C1_INIT = 3;
	localparam int C1_INV = 2;
	localparam int C1_SWAP = 1;
	localparam int C1_CLR = 0;
	// prescale divisors
	localparam int DIV_SYS4 = 4;
	localparam int DIV_H16 = 16;
	localparam int DIV_H64 = 64;
	localparam logic [1:0] MODE_COMPARE = 2'h0;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TIMER = 2'h3;
	localparam logic [2:0] CLK_SYS4 = 3'h0;
	localparam logic [2:0] CLK_SYS = 3'h1;
	localparam logic [2:0] CLK_H16 = 3'h2;
	localparam logic [2:0] CLK_H64 = 3'h3;
	localparam logic [2:0] CLK_SUB0 = 3'h4;
	localparam logic [2:0] CLK_SUB1 = 3'h5;
	localparam logic [2:0] CLK_EXT_RISE = 3'h6;
	localparam logic [2:0] CLK_EXT_FALL = 3'h7;
endpackage

// ===== src/tick_divider.sv
// pulse every DIV cycles while enabled
`timescale 1ns/1ps
module tick_divider
	import timer_pkg::*;
#(
	parameter int DIV = 4
) (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic run,
	output logic      tick
);
	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
	} div_state_type;
	div_state_type s_reg;
	div_state_type s_next;

	always_comb begin
		s_next = s_reg;
		s_next.tick = 1'b0;
		if (!run) begin
			s_next.cnt = 8'h00;
		end else if (s_reg.cnt == 8'(DIV - 1)) begin
			s_next.cnt = 8'h00;
			s_next.tick = 1'b1;
		end else begin
			s_next.cnt = s_reg.cnt + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign tick = s_reg.tick;
endmodule // tick_divider

// ===== src/pin_sync.sv
// two-stage synchroniser with edge pulses after the second stage
`timescale 1ns/1ps
module pin_sync (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic pin,
	output logic      rise,
	output logic      fall
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} sync_state_type;
	sync_state_type s_reg;
	sync_state_type s_next;

	always_comb begin
		s_next.s1 = pin;
		s_next.s2 = s_reg.s1;
		s_next.s3 = s_reg.s2;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rise = s_reg.s2 & ~s_reg.s3;
	assign fall = ~s_reg.s2 & s_reg.s3;
endmodule // pin_sync

// ===== src/compact_timer.sv
// compact 10-bit timer with compare, pwm and register port
// Overview of operation
// RL1 - pause holds count, timer stays powered
// RL2 - resume counts on from held value
// RL3 - clock select picks one of eight sources
// RL4 - on rising edge clears counter
// RL5 - off stops counting, keeps residual value
// RL6 - on rising edge loads initial output level
// RL7 - period compare matches counter bits 9..7
// RL8 - period value zero means full 1024
// RL9 - mode field: compare, pwm, timer
// RL10 - software turns timer off before mode change
// RL11 - compare match action: none, low, high, toggle
// RL12 - pwm action: inactive, active, waveform
// RL13 - action equal to level gives no change
// RL14 - software changes pwm action only when off
// RL15 - initial level or pwm active level
// RL16 - invert bit flips pin outside timer mode
// RL17 - swap bit exchanges period and duty roles
// RL18 - clear select one clears on compare a
// RL19 - clear select zero clears on period
// RL20 - clear select ignored in pwm mode
// RL21 - timer mode leaves output pin alone
// RL22 - compare a split low/high, upper zero
// RL23 - low byte buffered until high written
// RL24 - 10-bit counter, full compare a
// RL25 - undefined codes leave pin inactive
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module compact_timer
	import timer_pkg::*;
#(
	parameter int W = COUNT_WIDTH
) (
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire logic [ADDR_WIDTH-1:0] addr,
	input  wire logic [7:0]            wdata,
	input  wire logic                  wr,
	input  wire logic                  rd,
	output logic      [7:0]            rdata,
	input  wire logic                  high_clock_tick,
	input  wire logic                  sub_clock_tick,
	input  wire logic                  external_count_input,
	output logic                       timer_output_pin,
	output logic                       timer_output_pin_n,
	output logic                       pin_owned,
	output logic                       match_a,
	output logic                       match_p,
	output logic      [W-1:0]          count_value
);
	typedef struct packed {
		logic [7:0]   ctrl0;
		logic [7:0]   ctrl1;
		logic [7:0]   low_buf;
		logic [W-1:0] cmp_a;
		logic [W-1:0] count;
		logic         on_prev;
		logic         out_level;
		logic         pwm_raw;
		logic         match_a;
		logic         match_p;
		logic         pin;
		logic         pin_n;
		logic [7:0]   rdata;
	} timer_state_type;
	timer_state_type s_reg;
	timer_state_type s_next;

	logic tick_sys4;
	logic tick_h16;
	logic tick_h64;
	logic ext_rise;
	logic ext_fall;
	logic h16_sync_rise;
	logic h64_base;
	logic sub_rise;
	logic unused_h_fall;
	logic unused_s_fall;

	logic       on_bit;
	logic       pause;
	logic [2:0] clk_sel;
	logic [2:0] per_bits;
	logic [1:0] mode;
	logic [1:0] act;
	logic       init_lvl;
	logic       inv;
	logic       swap;
	logic       clr_sel;
	logic       tick;
	logic       hit_a;
	logic       hit_p;
	logic       at_max;
	logic       clear_now;
	logic       pwm_mode;
	logic       pwm_active;
	logic       logical_out;
	logic [W:0] period_len;
	logic [W:0] duty_len;

	assign on_bit   = s_reg.ctrl0[C0_ON];
	assign pause    = s_reg.ctrl0[C0_PAUSE];
	assign clk_sel  = s_reg.ctrl0[C0_CLK_HI:C0_CLK_LO];
	assign per_bits = s_reg.ctrl0[C0_PER_HI:0];
	assign mode     = s_reg.ctrl1[C1_MODE_HI:C1_MODE_LO];
	assign act      = s_reg.ctrl1[C1_ACT_HI:C1_ACT_LO];
	assign init_lvl = s_reg.ctrl1[C1_INIT];
	assign inv      = s_reg.ctrl1[C1_INV];
	assign swap     = s_reg.ctrl1[C1_SWAP];
	assign clr_sel  = s_reg.ctrl1[C1_CLR];
	assign pwm_mode = (mode == MODE_PWM);

	// prescalers run only while the timer is on, saving power when off
	tick_divider #(.DIV(DIV_SYS4)) u_div_sys4 (
		.clk  (clk),
		.nrst (nrst),
		.run  (on_bit),
		.tick (tick_sys4)
	);

	// high and sub clocks arrive from another domain, so sync them first
	pin_sync u_sync_high (
		.clk  (clk),
		.nrst (nrst),
		.pin  (high_clock_tick),
		.rise (h16_sync_rise),
		.fall (unused_h_fall)
	);

	pin_sync u_sync_sub (
		.clk  (clk),
		.nrst (nrst),
		.pin  (sub_clock_tick),
		.rise (sub_rise),
		.fall (unused_s_fall)
	);

	pin_sync u_sync_ext (
		.clk  (clk),
		.nrst (nrst),
		.pin  (external_count_input),
		.rise (ext_rise),
		.fall (ext_fall)
	);

	tick_divider #(.DIV(DIV_H16)) u_div_h16 (
		.clk  (clk),
		.nrst (nrst),
		.run  (on_bit),
		.tick (h64_base)
	);

	// high clock divided by counting its synchronised edges
	logic [5:0] h_cnt_reg;
	logic [5:0] h_cnt_next;
	always_comb begin
		h_cnt_next = h_cnt_reg;
		if (!on_bit) begin
			h_cnt_next = 6'h00;
		end else if (h16_sync_rise) begin
			h_cnt_next = h_cnt_reg + 6'h01;
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			h_cnt_reg <= 6'h00;
		end else begin
			h_cnt_reg <= h_cnt_next;
		end
	end
	assign tick_h16 = h16_sync_rise & (h_cnt_reg[3:0] == 4'hF);
	assign tick_h64 = h16_sync_rise & (h_cnt_reg == 6'h3F);

	// clock source selection [RL3]
	always_comb begin
		case (clk_sel)
			CLK_SYS4:     tick = tick_sys4;
			CLK_SYS:      tick = 1'b1;
			CLK_H16:      tick = tick_h16;
			CLK_H64:      tick = tick_h64;
			CLK_SUB0:     tick = sub_rise;
			CLK_SUB1:     tick = sub_rise;
			CLK_EXT_RISE: tick = ext_rise;
			CLK_EXT_FALL: tick = ext_fall;
			default:      tick = 1'b0;
		endcase
	end

	// comparators: a on all bits, p on top three bits [RL24] [RL7]
	// they look at the count about to be reached, so a clear on match
	// gives a period of exactly the programmed number of ticks
	assign hit_a  = (W'(s_reg.count + 1'b1) == s_reg.cmp_a);
	assign hit_p  = (s_reg.count[W-4:0] == '1) &&
		(3'(s_reg.count[W-1:W-3] + 3'h1) == per_bits);
	assign at_max = (s_reg.count == COUNT_MAX);

	// zero period code stands for the full range [RL8]
	always_comb begin
		period_len = '0;
		duty_len = '0;
		if (!swap) begin
			period_len = {per_bits == 3'h0, per_bits, 7'h00};
			duty_len = {1'b0, s_reg.cmp_a};
		end else begin
			period_len = {1'b0, s_reg.cmp_a};
			duty_len = {per_bits == 3'h0, per_bits, 7'h00};
		end
	end

	// counter clear source per mode [RL17] [RL18] [RL19] [RL20]
	always_comb begin
		if (pwm_mode) begin
			clear_now = swap ? hit_a : (hit_p | (per_bits == 3'h0 && at_max));
		end else if (clr_sel) begin
			clear_now = hit_a | at_max;
		end else begin
			clear_now = hit_p | (per_bits == 3'h0 && at_max);
		end
	end

	// pwm active while count below duty, full duty if duty >= period
	assign pwm_active = ({1'b0, s_reg.count} < duty_len) ||
		(duty_len >= period_len);

	always_comb begin
		s_next = s_reg;
		s_next.on_prev = on_bit;
		s_next.match_a = 1'b0;
		s_next.match_p = 1'b0;
		s_next.rdata = 8'h00;
		if (on_bit && !s_reg.on_prev) begin
			s_next.count = '0; // [RL4]
			s_next.out_level = init_lvl; // [RL6]
		end else if (on_bit && !pause && tick) begin
			// counting resumes from the held value after pause [RL1] [RL2]
			s_next.match_a = hit_a && s_reg.cmp_a != '0;
			s_next.match_p = hit_p && !(clr_sel && !pwm_mode);
			s_next.count = clear_now ? '0 : s_reg.count + 1'b1;
			if (mode == MODE_COMPARE && hit_a && s_reg.cmp_a != '0) begin
				// setting the level it already has is no change [RL11] [RL13]
				case (act)
					2'h0:    s_next.out_level = s_reg.out_level;
					2'h1:    s_next.out_level = 1'b0;
					2'h2:    s_next.out_level = 1'b1;
					2'h3:    s_next.out_level = ~s_reg.out_level;
					default: s_next.out_level = s_reg.out_level;
				endcase
			end
		end
		// when off the counter simply keeps its value [RL5]
		s_next.pwm_raw = pwm_active;

		// output pin function per mode [RL9] [RL12] [RL15] [RL25]
		case (mode)
			MODE_COMPARE: logical_out = s_reg.out_level;
			MODE_PWM: begin
				case (act)
					2'h0:    logical_out = ~init_lvl;
					2'h1:    logical_out = init_lvl;
					2'h2:    logical_out = s_reg.pwm_raw ? init_lvl : ~init_lvl;
					default: logical_out = ~init_lvl;
				endcase
			end
			MODE_TIMER: logical_out = 1'b0; // [RL21]
			default:    logical_out = ~init_lvl;
		endcase
		s_next.pin = (mode == MODE_TIMER) ? 1'b0 : logical_out ^ inv; // [RL16]
		s_next.pin_n = (mode == MODE_TIMER) ? 1'b0 : ~(logical_out ^ inv);

		// register port; low byte waits in a buffer [RL22] [RL23]
		if (wr) begin
			case (addr)
				ADDR_CMP_LOW:  s_next.low_buf = wdata;
				ADDR_CMP_HIGH: s_next.cmp_a = {wdata[1:0], s_reg.low_buf};
				ADDR_CTRL_0:   s_next.ctrl0 = wdata;
				ADDR_CTRL_1:   s_next.ctrl1 = wdata;
				default:       s_next.ctrl0 = s_reg.ctrl0;
			endcase
		end
		if (rd) begin
			case (addr)
				ADDR_CMP_LOW:  s_next.rdata = s_reg.cmp_a[7:0];
				ADDR_CMP_HIGH: s_next.rdata = {6'h00, s_reg.cmp_a[W-1:8]};
				ADDR_CTRL_0:   s_next.rdata = s_reg.ctrl0;
				ADDR_CTRL_1:   s_next.rdata = s_reg.ctrl1;
				default:       s_next.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rdata = s_reg.rdata;
	assign timer_output_pin = s_reg.pin;
	assign timer_output_pin_n = s_reg.pin_n;
	assign pin_owned = (mode != MODE_TIMER); // [RL21]
	assign match_a = s_reg.match_a;
	assign match_p = s_reg.match_p;
	assign count_value = s_reg.count;
endmodule // compact_timer

// ===== tb/ext_pin_model.sv
// external count pin model: free-running event source
`timescale 1ns/1ps
module ext_pin_model (
	input	wire logic	clk,
	input	wire logic	nrst,
	output	logic		external_count_input
);
	logic [1:0]	phase_reg;
	// runs free so both edge selects always see traffic
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			phase_reg <= 2'h0;
		else
			phase_reg <= phase_reg + 2'h1;
	end
	assign external_count_input = phase_reg[1];
endmodule // ext_pin_model

// ===== tb/compact_timer_assertions.sv
// assertion checker bound to the compact timer
`timescale 1ns/1ps
module compact_timer_check
	import timer_pkg::*;
#(
	parameter int W = COUNT_WIDTH
) (
	input wire logic			clk,
	input wire logic			nrst,
	input wire logic [ADDR_WIDTH-1:0]	addr,
	input wire logic [7:0]		wdata,
	input wire logic			wr,
	input wire logic			rd,
	input wire logic [7:0]		rdata,
	input wire logic			high_clock_tick,
	input wire logic			sub_clock_tick,
	input wire logic			external_count_input,
	input wire logic			timer_output_pin,
	input wire logic			timer_output_pin_n,
	input wire logic			pin_owned,
	input wire logic			match_a,
	input wire logic			match_p,
	input wire logic [W-1:0]		count_value
);
	logic	on_reg;
	logic	pause_reg;
	// shadow of two control bits, tracked from the bus
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			on_reg <= 1'b0;
			pause_reg <= 1'b0;
		end else if (wr && addr == ADDR_CTRL_0) begin
			on_reg <= wdata[C0_ON];
			pause_reg <= wdata[C0_PAUSE];
		end
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	high_zero_a: assert property (
		$past(rd) && $past(addr) == ADDR_CMP_HIGH |-> rdata[7:2] == 6'h00
	) else $error("compare high upper bits set");
	count_hold_a: assert property (
		(pause_reg || !on_reg) && ($past(pause_reg) || !$past(on_reg))
		|-> $stable(count_value)
	) else $error("count moved while held");
	on_clear_a: assert property (
		$rose(on_reg) |-> ##[0:1] count_value == '0
	) else $error("count not cleared at switch on");
	count_step_a: assert property (
		!$stable(count_value) |-> count_value == '0
			|| count_value == $past(count_value) + 1'b1
	) else $error("count jumped");
	timer_quiet_a: assert property (
		!pin_owned && !$past(pin_owned)
		|-> !timer_output_pin && !timer_output_pin_n
	) else $error("pin driven in timer mode");
	pin_pair_a: assert property (
		$past(nrst, 2) && pin_owned && $past(pin_owned)
		|-> timer_output_pin_n != timer_output_pin
	) else $error("pin pair not inverse");
	match_a_pulse_a: assert property (
		match_a |=> !match_a
	) else $error("compare match held");
	match_p_pulse_a: assert property (
		match_p |=> !match_p
	) else $error("period match held");
	cover property (match_a);
	cover property (match_p);
	cover property (pause_reg && on_reg);
endmodule // compact_timer_check

bind compact_timer compact_timer_check #(.W(W)) check_i (
	.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .high_clock_tick,
	.sub_clock_tick, .external_count_input, .timer_output_pin,
	.timer_output_pin_n, .pin_owned, .match_a, .match_p, .count_value
);

// ===== tb/testbench.sv
// self-checking bench for the compact timer
`timescale 1ns/1ps
`define CHK(g, e) begin \
	checked++; \
	if ((g) !== (e)) begin \
		miscompares++; \
		$display("[ERR] %0t got %0h exp %0h", $time, g, e); \
	end \
end
module testbench
	import timer_pkg::*;
;
	typedef struct {
		logic [7:0]	c1;
		logic [9:0]	a;
		logic [7:0]	c0;
		int		n, hi, ma, mp, d;
	} row_type;
	logic		clk = 1'b0;
	logic		nrst = 1'b0;
	logic [1:0]	addr = 2'h0;
	logic [7:0]	wdata = 8'h00;
	logic		wr = 1'b0;
	logic		rd = 1'b0;
	logic		high_clock_tick = 1'b0;
	logic		sub_clock_tick = 1'b0;
	logic [2:0]	div5 = 3'h0;
	logic [7:0]	rdata, v;
	logic [9:0]	count_value, c;
	logic		external_count_input, timer_output_pin;
	logic		timer_output_pin_n, pin_owned, match_a, match_p;
	int		miscompares = 0;
	int		checked = 0;
	int		cycles = 0;
	// -1 marks a tally that is not compared
	row_type rows [23] = '{
		'{8'h30, 10'h040, 8'h19, 512, 256, 4, 4, -1},
		'{8'h00, 10'h000, 8'h18, 1000, 0, 0, -1, 1000},
		'{8'h01, 10'h0C8, 8'h19, 600, 0, 3, -1, -1},
		'{8'hA9, 10'h020, 8'h19, 256, 64, 2, 2, -1},
		'{8'hAA, 10'h12C, 8'h19, 600, 256, 2, -1, -1},
		'{8'h88, 10'h020, 8'h19, 256, 0, -1, -1, -1},
		'{8'h98, 10'h020, 8'h19, 256, 256, -1, -1, -1},
		'{8'hB8, 10'h020, 8'h19, 256, 0, -1, -1, -1},
		'{8'hA0, 10'h020, 8'h19, 256, 192, -1, -1, -1},
		'{8'hA4, 10'h020, 8'h19, 256, 64, -1, -1, -1},
		'{8'hF8, 10'h020, 8'h19, 256, 0, -1, -1, -1},
		'{8'h4C, 10'h020, 8'h19, 256, 256, -1, -1, -1},
		'{8'h28, 10'h020, 8'h19, 256, 256, -1, -1, -1},
		'{8'h10, 10'h020, 8'h19, 256, 0, -1, -1, -1},
		'{8'h00, 10'h000, 8'h08, 640, 0, -1, -1, 160},
		'{8'h00, 10'h000, 8'h18, 640, 0, -1, -1, 640},
		'{8'h00, 10'h000, 8'h28, 640, 0, -1, -1, 20},
		'{8'h00, 10'h000, 8'h38, 640, 0, -1, -1, 5},
		'{8'h00, 10'h000, 8'h48, 640, 0, -1, -1, 64},
		'{8'h00, 10'h000, 8'h58, 640, 0, -1, -1, 64},
		'{8'h00, 10'h000, 8'h68, 640, 0, -1, -1, 160},
		'{8'h00, 10'h000, 8'h78, 640, 0, -1, -1, 160},
		'{8'h00, 10'h000, 8'h18, 64, 0, 0, -1, 64}
	};
	compact_timer dut (
		.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .high_clock_tick,
		.sub_clock_tick, .external_count_input, .timer_output_pin,
		.timer_output_pin_n, .pin_owned, .match_a, .match_p, .count_value
	);
	ext_pin_model pin_i (.clk, .nrst, .external_count_input);
	task automatic wreg(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [1:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask
	task automatic run_row(input row_type r);
		int		hi = 0;
		int		ma = 0;
		int		mp = 0;
		logic [9:0]	dd;
		wreg(ADDR_CTRL_0, CTRL_RESET);
		wreg(ADDR_CMP_LOW, r.a[7:0]);
		wreg(ADDR_CMP_HIGH, {6'h00, r.a[9:8]});
		wreg(ADDR_CTRL_1, r.c1);
		wreg(ADDR_CTRL_0, r.c0);
		// skip start-up so the window sees the steady waveform
		repeat (4) @(negedge clk);
		c = count_value;
		repeat (r.n) begin
			@(negedge clk);
			hi += timer_output_pin;
			ma += match_a;
			mp += match_p;
		end
		dd = count_value - c;
		`CHK(pin_owned, r.c1[7:6] != MODE_TIMER)
		`CHK(hi, r.hi)
		if (r.ma >= 0) `CHK(ma, r.ma)
		if (r.mp >= 0) `CHK(mp, r.mp)
		if (r.d >= 0) `CHK(dd inside {[r.d - 1:r.d + 1]}, 1'b1)
	endtask
	task automatic finish_test();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		high_clock_tick <= ~high_clock_tick;
		div5 <= (div5 == 3'h4) ? 3'h0 : div5 + 3'h1;
		if (div5 == 3'h4)
			sub_clock_tick <= ~sub_clock_tick;
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			finish_test();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rreg(2'(i));
			`CHK(v, CTRL_RESET)
		end
		wreg(ADDR_CMP_LOW, 8'h5A);
		rreg(ADDR_CMP_LOW);
		`CHK(v, 8'h00)
		wreg(ADDR_CMP_HIGH, 8'hFF);
		rreg(ADDR_CMP_HIGH);
		`CHK(v, 8'h03)
		rreg(ADDR_CMP_LOW);
		`CHK(v, 8'h5A)
		$display("register test done");
		foreach (rows[i]) begin
			run_row(rows[i]);
			$display("row %0d done", i);
		end
		wreg(ADDR_CTRL_0, 8'h98);
		repeat (3) @(negedge clk);
		c = count_value;
		repeat (20) @(negedge clk);
		`CHK(count_value, c)
		wreg(ADDR_CTRL_0, 8'h18);
		repeat (10) @(negedge clk);
		`CHK((count_value - c) inside {[10'd8:10'd12]}, 1'b1)
		$display("pause test done");
		finish_test();
	end
endmodule // testbench
